// *** common/iavs_pkg.sv ***
`default_nettype none
package iavs_pkg;
  // ========================================================
  // addresses and vector table
  localparam int unsigned   ADDR_W       = 15;
  localparam logic [14:0]   ENTRY_ADDR   = 15'h00ff;
  localparam logic [7:0]    TABLE_BASE   = 8'he0;
  localparam logic [7:0]    BLOCK_LAST   = 8'hff;
  localparam logic [15:0]   MASKABLE     = 16'h3ffe;
  localparam int unsigned   TRAP_IDX     = 15;
  // ========================================================
  // timing, in instruction cycles of one clock each
  localparam int unsigned   ACK_CYCLES   = 7;
  localparam logic [2:0]    ACK_LAST     = 3'(ACK_CYCLES - 1);
  localparam logic [2:0]    ACK_LOAD     = 3'(ACK_CYCLES - 2);
  // ========================================================
  // register byte offsets
  localparam logic [7:0]    REG_ENABLE   = 8'h00;
  localparam logic [7:0]    REG_PENDING  = 8'h04;
  localparam logic [7:0]    REG_CONTROL  = 8'h08;
  localparam logic [7:0]    REG_STATUS   = 8'h0c;
  localparam logic [15:0]   ENABLE_RST   = 16'h0000;
  localparam logic [15:0]   PENDING_RST  = 16'h0000;
  localparam logic          GIE_RST      = 1'b0;
  localparam int unsigned   CTRL_GIE_BIT = 0;
  localparam int unsigned   STAT_GIE     = 0;
  localparam int unsigned   STAT_TRAP    = 1;
  localparam int unsigned   STAT_BUSY    = 2;
  localparam int unsigned   STAT_TOP_LSB = 8;
  localparam int unsigned   STAT_OFF_LSB = 16;
  // ========================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ACK    = 3'h1,
    ST_VIS_HI = 3'h2,
    ST_VIS_LO = 3'h6,
    ST_VIS_LD = 3'h4
  } iavs_state_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } iavs_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } iavs_wb_rsp_type;

  typedef struct packed {
    logic        instr_start;
    logic        skip;
    logic [14:0] pc;
    logic        vis_exec;
    logic [14:0] vis_addr;
    logic        return_from_int_instr;
    logic [14:0] pop_addr;
    logic        trap;
    logic        clear_trap_pending_instr;
    logic        psw_wr;
    logic        psw_gie;
    logic        boot_rom;
  } iavs_core_req_type;

  typedef struct packed {
    logic        busy;
    logic        pc_load;
    logic [14:0] pc;
    logic        push;
    logic [14:0] push_data;
    logic        mem_rd;
    logic [14:0] mem_addr;
  } iavs_core_cmd_type;

  typedef struct packed {
    iavs_state_type st;
    logic [2:0]     cnt;
    logic           global_int_enable;
    logic           trap_pnd;
    logic           trap_req;
    logic [15:0]    en;
    logic [15:0]    pnd;
    logic [7:0]     hi_byte;
    logic [7:0]     vis_off;
    logic           pc_load;
    logic [14:0]    pc;
    logic           push;
    logic [14:0]    push_data;
    logic           mem_rd;
    logic [14:0]    mem_addr;
    logic           wb_ack;
    logic [31:0]    wb_dat;
  } iavs_regs_type;
endpackage
`default_nettype wire

// *** hw/iavs_top.sv ***
// How it works
// R1: a source is active only when its enable and pending bits are both set
// R2: enabling an already pending source requests at once when global enable set
// R3: requests are acknowledged only at the start of the next instruction
// R4: a skipped instruction is skipped first, acknowledge waits for next boundary
// R5: acknowledge start of a maskable source clears the global enable
// R6: acknowledge pushes the address of the instruction about to execute
// R7: acknowledge loads the program counter with entry address 00ff
// R8: the acknowledge sequence lasts seven instruction cycles
// R9: a status word write may set global enable for nesting
// R10: return sets global enable, loads the popped address into the counter
// R11: a still pending source is taken at the boundary after return
// R12: boot rom execution blocks maskable acknowledge, global enable kept unchanged
// R13: repeated events of a pending source collapse to one pending bit
// R14: vector select picks top enabled pending source, jumps through its entry
// R15: table sits at top of the 256-byte block holding vector select
// R16: vector select on a block's last byte uses the next block's table
// R17: vector is 15 bits, high byte at the lower address
// R18: lowest rank at offset e0, each rank two above, trap at fe
// R19: simultaneous sources are served highest rank first
// R20: no active source gives the default lowest vector
// R21: offset sampled in first cycle replaces low counter byte, then jump
// R22: reset clears pending, enable and global enable bits
// R23: trap pending inhibits maskable sources, cleared by clear-trap or reset
// R24: maskable request needs enable, global enable, no trap in service
// R25: fixed priority encoder, index doubled plus e0 forms table offset
`timescale 1ns/1ps
`default_nettype none
module iavs_top (
  input  wire logic                       CLK_SYS_IN,
  input  wire logic                       RESETN_IN,
  input  wire logic                       CE_IN,
  input  wire iavs_pkg::iavs_wb_req_type  WB_REQ_IN,
  output var iavs_pkg::iavs_wb_rsp_type   WB_RSP_OUT,
  input  wire iavs_pkg::iavs_core_req_type CORE_IN,
  output var iavs_pkg::iavs_core_cmd_type CORE_OUT,
  input  wire logic [15:0]                SRC_EVENT_IN,
  input  wire logic [7:0]                 MEM_DATA_IN
);

  // ========================================================
  // helpers
  function automatic logic [3:0] top_rank(input logic [15:0] act);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 1; i < 16; i++) begin
      if (act[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [7:0] rank_offset(input logic [3:0] idx);
    return iavs_pkg::TABLE_BASE + {3'h0, idx, 1'b0};
  endfunction

  // ========================================================
  // state
  iavs_pkg::iavs_regs_type r_q;
  iavs_pkg::iavs_regs_type r_d;

  logic [15:0] active;
  logic [15:0] vis_act;
  logic [7:0]  vis_off;
  logic [6:0]  vis_blk;
  logic        mask_req;
  logic        boundary;
  logic        ack_go;
  logic        vis_go;
  logic        return_from_int_instr_go;
  logic        wb_go;

  assign active   = r_q.en & r_q.pnd & iavs_pkg::MASKABLE; // R1
  // trap in service holds off every maskable source
  assign mask_req = r_q.global_int_enable & (|active) & ~r_q.trap_pnd; // R2 R24 R23
  // skipped instruction is not a normal boundary
  assign boundary = CORE_IN.instr_start & ~CORE_IN.skip
                  & (r_q.st == iavs_pkg::ST_IDLE); // R3 R4
  assign ack_go   = boundary & (r_q.trap_req
                  | (mask_req & ~CORE_IN.boot_rom)); // R12 R11
  assign return_from_int_instr_go  = CORE_IN.return_from_int_instr & (r_q.st == iavs_pkg::ST_IDLE);
  assign vis_go   = CORE_IN.vis_exec & (r_q.st == iavs_pkg::ST_IDLE)
                  & ~ack_go & ~return_from_int_instr_go;
  assign vis_act  = {r_q.trap_pnd, active[14:0]};
  assign vis_off  = rank_offset(top_rank(vis_act)); // R25 R19 R20 R18
  assign vis_blk  = (CORE_IN.vis_addr[7:0] == iavs_pkg::BLOCK_LAST)
                  ? CORE_IN.vis_addr[14:8] + 7'h01
                  : CORE_IN.vis_addr[14:8]; // R15 R16
  assign wb_go    = WB_REQ_IN.cyc & WB_REQ_IN.stb & ~r_q.wb_ack;

  // ========================================================
  // next state
  always_comb begin
    r_d         = r_q;
    r_d.pc_load = 1'b0;
    r_d.push    = 1'b0;
    r_d.mem_rd  = 1'b0;
    r_d.wb_ack  = wb_go;

    // status word write, nested servicing
    if (CORE_IN.psw_wr) begin
      r_d.global_int_enable = CORE_IN.psw_gie; // R9
    end

    // register bus
    if (wb_go) begin
      r_d.wb_dat = 32'h0000_0000;
      unique case (WB_REQ_IN.adr)
        iavs_pkg::REG_ENABLE: begin
          r_d.wb_dat[15:0] = r_q.en;
          if (WB_REQ_IN.we) begin
            if (WB_REQ_IN.sel[0]) begin
              r_d.en[7:0] = WB_REQ_IN.dat[7:0]
                          & iavs_pkg::MASKABLE[7:0];
            end
            if (WB_REQ_IN.sel[1]) begin
              r_d.en[15:8] = WB_REQ_IN.dat[15:8]
                           & iavs_pkg::MASKABLE[15:8];
            end
          end
        end
        iavs_pkg::REG_PENDING: begin
          r_d.wb_dat[15:0] = r_q.pnd;
          if (WB_REQ_IN.we) begin
            if (WB_REQ_IN.sel[0]) begin
              r_d.pnd[7:0] = r_q.pnd[7:0] & ~WB_REQ_IN.dat[7:0];
            end
            if (WB_REQ_IN.sel[1]) begin
              r_d.pnd[15:8] = r_q.pnd[15:8] & ~WB_REQ_IN.dat[15:8];
            end
          end
        end
        iavs_pkg::REG_CONTROL: begin
          r_d.wb_dat[iavs_pkg::CTRL_GIE_BIT] = r_q.global_int_enable;
          if (WB_REQ_IN.we && WB_REQ_IN.sel[0]) begin
            r_d.global_int_enable = WB_REQ_IN.dat[iavs_pkg::CTRL_GIE_BIT]; // R9
          end
        end
        iavs_pkg::REG_STATUS: begin
          r_d.wb_dat[iavs_pkg::STAT_GIE]  = r_q.global_int_enable;
          r_d.wb_dat[iavs_pkg::STAT_TRAP] = r_q.trap_pnd;
          r_d.wb_dat[iavs_pkg::STAT_BUSY] =
            (r_q.st != iavs_pkg::ST_IDLE);
          r_d.wb_dat[iavs_pkg::STAT_TOP_LSB +: 4] = top_rank(vis_act);
          r_d.wb_dat[iavs_pkg::STAT_OFF_LSB +: 8] = r_q.vis_off;
        end
        default: begin
          r_d.wb_dat = 32'h0000_0000;
        end
      endcase
    end

    // events last: set wins over a same-cycle clear
    r_d.pnd = r_d.pnd | (SRC_EVENT_IN & iavs_pkg::MASKABLE); // R13

    // trap: set wins over clear-trap
    if (CORE_IN.clear_trap_pending_instr) begin
      r_d.trap_pnd = 1'b0; // R23
    end
    if (CORE_IN.trap) begin
      r_d.trap_pnd = 1'b1;
      r_d.trap_req = 1'b1;
    end

    unique case (r_q.st)
      iavs_pkg::ST_IDLE: begin
        if (ack_go) begin
          r_d.st        = iavs_pkg::ST_ACK;
          r_d.cnt       = 3'h0;
          r_d.push      = 1'b1; // R6
          r_d.push_data = CORE_IN.pc; // R6
          if (r_q.trap_req) begin
            // trap leaves global enable as it was
            r_d.trap_req = CORE_IN.trap;
          end else begin
            r_d.global_int_enable = 1'b0; // R5
          end
        end else if (return_from_int_instr_go) begin
          r_d.global_int_enable     = 1'b1; // R10
          r_d.pc      = CORE_IN.pop_addr; // R10
          r_d.pc_load = 1'b1; // R10
        end else if (vis_go) begin
          r_d.vis_off  = vis_off; // R21
          r_d.mem_addr = {vis_blk, vis_off}; // R14
          r_d.mem_rd   = 1'b1;
          r_d.st       = iavs_pkg::ST_VIS_HI;
        end
      end
      iavs_pkg::ST_ACK: begin
        r_d.cnt = r_q.cnt + 3'h1;
        if (r_q.cnt == iavs_pkg::ACK_LOAD) begin
          r_d.pc      = iavs_pkg::ENTRY_ADDR; // R7
          r_d.pc_load = 1'b1; // R7
        end
        if (r_q.cnt == iavs_pkg::ACK_LAST) begin
          r_d.st = iavs_pkg::ST_IDLE; // R8
        end
      end
      iavs_pkg::ST_VIS_HI: begin
        r_d.mem_addr = {r_q.mem_addr[14:1], 1'b1}; // R17
        r_d.mem_rd   = 1'b1;
        r_d.st       = iavs_pkg::ST_VIS_LO;
      end
      iavs_pkg::ST_VIS_LO: begin
        r_d.hi_byte = MEM_DATA_IN; // R17
        r_d.st      = iavs_pkg::ST_VIS_LD;
      end
      iavs_pkg::ST_VIS_LD: begin
        r_d.pc      = {r_q.hi_byte[6:0], MEM_DATA_IN}; // R17 R14
        r_d.pc_load = 1'b1;
        r_d.st      = iavs_pkg::ST_IDLE;
      end
      default: begin
        r_d.st = iavs_pkg::ST_IDLE;
      end
    endcase
  end

  // ========================================================
  // registers
  localparam iavs_pkg::iavs_regs_type REGS_RST = '{
    st:        iavs_pkg::ST_IDLE,
    cnt:       3'h0,
    global_int_enable:       iavs_pkg::GIE_RST,
    trap_pnd:  1'b0,
    trap_req:  1'b0,
    en:        iavs_pkg::ENABLE_RST,
    pnd:       iavs_pkg::PENDING_RST,
    hi_byte:   8'h00,
    vis_off:   8'h00,
    pc_load:   1'b0,
    pc:        15'h0000,
    push:      1'b0,
    push_data: 15'h0000,
    mem_rd:    1'b0,
    mem_addr:  15'h0000,
    wb_ack:    1'b0,
    wb_dat:    32'h0000_0000
  };

  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      r_q <= REGS_RST; // R22
    end else if (CE_IN) begin
      r_q <= r_d;
    end
  end

  assign WB_RSP_OUT.ack     = r_q.wb_ack;
  assign WB_RSP_OUT.dat     = r_q.wb_dat;
  assign CORE_OUT.busy      = (r_q.st != iavs_pkg::ST_IDLE);
  assign CORE_OUT.pc_load   = r_q.pc_load;
  assign CORE_OUT.pc        = r_q.pc;
  assign CORE_OUT.push      = r_q.push;
  assign CORE_OUT.push_data = r_q.push_data;
  assign CORE_OUT.mem_rd    = r_q.mem_rd;
  assign CORE_OUT.mem_addr  = r_q.mem_addr;

  // ========================================================
  // checks
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);

  logic ack_start;
  assign ack_start = CE_IN & ack_go;

  sequence s_vis_go;
    CE_IN && vis_go ##1 CE_IN [*3];
  endsequence

  sequence s_vis_done;
    r_q.pc_load && (r_q.st == iavs_pkg::ST_IDLE);
  endsequence

  a_gie_ack_clear: assert property (ack_start && !r_q.trap_req // R5
      && !CORE_IN.psw_wr |=> !r_q.global_int_enable)
    else $error("global enable not cleared on acknowledge");

  a_push_return: assert property (ack_start |=> r_q.push // R6
      && r_q.push_data == $past(CORE_IN.pc))
    else $error("return address not pushed");

  a_entry_load: assert property (r_q.st == iavs_pkg::ST_ACK // R7
      && r_q.pc_load |-> r_q.pc == 15'h00ff && r_q.cnt == 3'h6)
    else $error("entry address wrong");

  a_ack_seven: assert property (CE_IN && r_q.st == iavs_pkg::ST_ACK // R8
      && r_q.cnt == 3'h6 |=> r_q.st == iavs_pkg::ST_IDLE)
    else $error("acknowledge not seven cycles");

  a_mid_instr: assert property (CE_IN && !CORE_IN.instr_start // R3
      && r_q.st == iavs_pkg::ST_IDLE |=> r_q.st != iavs_pkg::ST_ACK)
    else $error("acknowledge outside boundary");

  a_skip_first: assert property (CE_IN && CORE_IN.skip // R4
      && r_q.st == iavs_pkg::ST_IDLE |=> r_q.st != iavs_pkg::ST_ACK)
    else $error("acknowledge during skip");

  a_boot_block: assert property (CE_IN && CORE_IN.boot_rom // R12
      && !r_q.trap_req && r_q.st == iavs_pkg::ST_IDLE
      |=> r_q.st != iavs_pkg::ST_ACK && r_q.global_int_enable == $past(r_q.global_int_enable))
    else $error("boot rom not blocking");

  a_trap_hold: assert property (CE_IN && r_q.trap_pnd // R23
      && !r_q.trap_req && r_q.st == iavs_pkg::ST_IDLE
      |=> r_q.st != iavs_pkg::ST_ACK)
    else $error("maskable taken during trap service");

  a_return_from_int_instr_load: assert property (CE_IN && return_from_int_instr_go && !ack_go // R10
      |=> r_q.global_int_enable && r_q.pc_load && r_q.pc == $past(CORE_IN.pop_addr))
    else $error("return did not restore");

  a_vis_offset: assert property (CE_IN && vis_go |=> r_q.mem_rd // R21
      && r_q.mem_addr[7:0] == $past(vis_off) && !r_q.mem_addr[0])
    else $error("vector select offset wrong");

  a_vis_jump: assert property (s_vis_go |=> s_vis_done) // R14
    else $error("vector select did not jump");

endmodule
`default_nettype wire

// *** testbench/iavs_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========================================
// program memory behind the vector fetch
module iavs_mem_model (
  input  wire logic        clk_in,
  input  wire logic        rd_in,
  input  wire logic [14:0] addr_in,
  output var  logic [7:0]  data_out
);
  initial begin
    data_out = 8'h00;
  end
  // byte lands the cycle after the read strobe
  // between reads the bus toggles so a late sample cannot pass by luck
  always @(posedge clk_in) begin
    if (rd_in) begin
      data_out <= addr_in[7:0] ^ 8'h3c;
    end else begin
      data_out <= ~data_out;
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb_interrupt_ack_vector_select.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_ack_vector_select;
  logic                        clk;
  logic                        rst_n;
  logic                        ce;
  logic [15:0]                 ev;
  logic [7:0]                  mem;
  logic [31:0]                 rd;
  int                          bad_count;
  int                          tests_run;
  iavs_pkg::iavs_wb_req_type   wb;
  iavs_pkg::iavs_wb_rsp_type   rsp;
  iavs_pkg::iavs_core_req_type core;
  iavs_pkg::iavs_core_req_type c;
  iavs_pkg::iavs_core_cmd_type co;

  iavs_top uut (
    .CLK_SYS_IN  (clk),
    .RESETN_IN   (rst_n),
    .CE_IN       (ce),
    .WB_REQ_IN   (wb),
    .WB_RSP_OUT  (rsp),
    .CORE_IN     (core),
    .CORE_OUT    (co),
    .SRC_EVENT_IN(ev),
    .MEM_DATA_IN (mem)
  );
  iavs_mem_model pmem (
    .clk_in  (clk),
    .rd_in   (co.mem_rd),
    .addr_in (co.mem_addr),
    .data_out(mem)
  );

  // ========================================
  // helpers
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // classic single cycle, held until ack is seen at an edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb <= '{1'b1, 1'b1, w, 4'h3, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      close_out();
    end
    rd = rsp.dat;
    wb <= '0;
  endtask

  task automatic evt(input logic [15:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= '0;
  endtask

  // one-cycle core request; returns settled inside c1
  task automatic go(input iavs_pkg::iavs_core_req_type r);
    @(posedge clk);
    core <= r;
    @(posedge clk);
    core <= '0;
    #1;
  endtask

  task automatic take(input logic [14:0] p);
    c = '0;
    c.instr_start = 1'b1;
    c.pc = p;
    go(c);
    chk({15'h0, 2'b11, p}, {15'h0, co.busy, co.push, co.push_data});
    for (int i = 2; i < 8; i++) begin
      chk(32'h1, 32'(co.busy));
      @(posedge clk);
      #1;
    end
    chk({16'h1, 15'h00ff}, {16'h0, co.pc_load, co.pc});
    @(posedge clk);
    #1;
    chk(32'h0, 32'(co.busy));
  endtask

  task automatic no_take(input logic s, input logic b);
    c = '0;
    c.instr_start = 1'b1;
    c.skip = s;
    c.boot_rom = b;
    c.pc = 15'h0abc;
    go(c);
    chk(32'h0, 32'(co.busy));
  endtask

  task automatic vector_select_instr(input logic [14:0] va, input logic [14:0] ea);
    logic [7:0] h;
    h = ea[7:0] ^ 8'h3c;
    c = '0;
    c.vis_exec = 1'b1;
    c.vis_addr = va;
    go(c);
    chk({16'h1, ea}, {16'h0, co.mem_rd, co.mem_addr});
    @(posedge clk);
    #1;
    chk({16'h1, ea | 15'h1}, {16'h0, co.mem_rd, co.mem_addr});
    repeat (2) @(posedge clk);
    #1;
    chk({16'h1, h[6:0], h ^ 8'h01}, {16'h0, co.pc_load, co.pc});
  endtask

  task automatic set_gie();
    c = '0;
    c.psw_wr = 1'b1;
    c.psw_gie = 1'b1;
    go(c);
  endtask

  // ========================================
  // stimulus
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    ev = '0;
    wb = '0;
    core = '0;
    c = '0;
    rd = '0;
    bad_count = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      chk(32'h0, rd);
    end
    $display("reset test done");
    evt(16'h0020);
    evt(16'h0020);
    bus(1'b0, 8'h04, 32'h0);
    chk(32'h20, rd);
    bus(1'b1, 8'h08, 32'h1);
    no_take(1'b0, 1'b0);
    evt(16'h0200);
    bus(1'b1, 8'h00, 32'hffff);
    bus(1'b0, 8'h00, 32'h0);
    chk(32'h3ffe, rd);
    take(15'h1234);
    bus(1'b0, 8'h0c, 32'h0);
    chk(32'h0900, rd & 32'hffff);
    $display("acknowledge test done");
    vector_select_instr(15'h01ff, 15'h02f2);
    vector_select_instr(15'h0345, 15'h03f2);
    bus(1'b1, 8'h04, 32'h200);
    vector_select_instr(15'h0345, 15'h03ea);
    $display("vector select test done");
    c = '0;
    c.return_from_int_instr = 1'b1;
    c.pop_addr = 15'h1234;
    go(c);
    chk({16'h1, 15'h1234}, {16'h0, co.pc_load, co.pc});
    bus(1'b0, 8'h0c, 32'h0);
    chk(32'h1, rd & 32'h1);
    take(15'h1234);
    $display("return test done");
    set_gie();
    bus(1'b0, 8'h0c, 32'h0);
    chk(32'h1, rd & 32'h1);
    no_take(1'b1, 1'b0);
    no_take(1'b0, 1'b1);
    bus(1'b0, 8'h0c, 32'h0);
    chk(32'h1, rd & 32'h1);
    take(15'h0200);
    $display("skip and boot test done");
    c = '0;
    c.trap = 1'b1;
    go(c);
    take(15'h0300);
    bus(1'b0, 8'h0c, 32'h0);
    chk(32'h0f02, rd & 32'hffff);
    vector_select_instr(15'h0100, 15'h01fe);
    set_gie();
    no_take(1'b0, 1'b0);
    c = '0;
    c.clear_trap_pending_instr = 1'b1;
    go(c);
    take(15'h0400);
    $display("trap test done");
    bus(1'b1, 8'h04, 32'h20);
    vector_select_instr(15'h0310, 15'h03e0);
    $display("default vector test done");
    // frozen clock enable: an event seen while frozen must not land
    @(posedge clk);
    ce <= 1'b0;
    evt(16'h0020);
    @(posedge clk);
    ce <= 1'b1;
    bus(1'b0, 8'h04, 32'h0);
    chk(32'h0, rd);
    $display("clock enable test done");
    close_out();
  end
endmodule
`default_nettype wire
